// ### hdl/psac_perf_counters.sv
// What this block does
// - transitions start only while enable bit 16 set
// - feature leaf reports transition support, ecx bit 7
// - writing 16-bit target starts a transition
// - target written mid-transition runs afterwards
// - target register reads last requested point
// - status register shows live current point
// - point encoding is a configurable parameter
// - each change is one discrete step
// - power leaf ecx bit 0 reports counters
// - reference counter counts fixed-rate ticks
// - actual counter counts delivered performance ticks
// - counters per processor, count only in c0
// - either counter wrapping clears both
// - 64-bit counters, each written independently
// - target bit 32 suspends boost, not in status
`timescale 1ns/1ns
module psac_perf_counters #(
    parameter logic [15:0] POINT_MASK = psac_pkg::OP_POINT_MASK,
    parameter logic [15:0] POINT_RESET = psac_pkg::OP_POINT_RESET
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_rd_en,
    input wire logic reg_wr_en,
    input wire logic [31:0] reg_addr,
    input wire logic [63:0] reg_wr_data,
    output logic [63:0] reg_rd_data,
    output logic reg_rd_valid,
    output logic reg_fault,
    input wire logic id_req,
    input wire logic [31:0] id_leaf,
    output logic [31:0] id_ecx,
    output logic id_valid,
    input wire logic c0_active,
    input wire logic ref_tick,
    input wire logic perf_tick,
    output logic [15:0] op_point,
    output logic transition_busy,
    output logic boost_suspend
);

// ----------------------------------------------------------------
// address decode
// ----------------------------------------------------------------
function automatic psac_pkg::psac_sel_type decode(input logic [31:0] addr);
    if (addr == psac_pkg::ADDR_FIXED_REF) begin
        return psac_pkg::SEL_REF;
    end else if (addr == psac_pkg::ADDR_ACTUAL_PERF) begin
        return psac_pkg::SEL_ACT;
    end else if (addr == psac_pkg::ADDR_PERF_STATUS) begin
        return psac_pkg::SEL_STATUS;
    end else if (addr == psac_pkg::ADDR_PERF_CTL) begin
        return psac_pkg::SEL_CTL;
    end else if (addr == psac_pkg::ADDR_MISC_ENABLE) begin
        return psac_pkg::SEL_MISC;
    end else begin
        return psac_pkg::SEL_NONE;
    end
endfunction

psac_pkg::psac_sel_type sel;
logic [63:0] ref_ff;
logic [63:0] act_ff;
logic [63:0] ctl_ff;
logic misc_en_ff;
logic [63:0] rd_data_ff;
logic rd_valid_ff;
logic fault_ff;
logic [31:0] ecx_ff;
logic id_valid_ff;
logic wr_ref;
logic wr_act;
logic wr_ctl;
logic wr_misc;
logic ref_inc;
logic act_inc;
logic wrap;
logic [15:0] cur_point;
logic busy;
logic [63:0] nxt_rd_data;

assign sel = decode(reg_addr);
assign wr_ref = reg_wr_en && (sel == psac_pkg::SEL_REF);
assign wr_act = reg_wr_en && (sel == psac_pkg::SEL_ACT);
assign wr_ctl = reg_wr_en && (sel == psac_pkg::SEL_CTL);
assign wr_misc = reg_wr_en && (sel == psac_pkg::SEL_MISC);

// ----------------------------------------------------------------
// activity counters
// ----------------------------------------------------------------
assign ref_inc = c0_active && ref_tick;
assign act_inc = c0_active && perf_tick;
assign wrap = (ref_inc && (&ref_ff)) || (act_inc && (&act_ff));

always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
        ref_ff <= psac_pkg::COUNTER_RESET;
    end else if (wr_ref) begin
        ref_ff <= reg_wr_data;
    end else if (wrap) begin
        ref_ff <= 64'h0;
    end else if (ref_inc) begin
        ref_ff <= ref_ff + 64'h1;
    end
end

always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
        act_ff <= psac_pkg::COUNTER_RESET;
    end else if (wr_act) begin
        act_ff <= reg_wr_data;
    end else if (wrap) begin
        act_ff <= 64'h0;
    end else if (act_inc) begin
        act_ff <= act_ff + 64'h1;
    end
end

// ----------------------------------------------------------------
// control and enable registers
// ----------------------------------------------------------------
always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
        ctl_ff <= psac_pkg::CTL_RESET;
    end else if (wr_ctl) begin
        ctl_ff <= reg_wr_data;
    end
end

always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
        misc_en_ff <= 1'b0;
    end else if (wr_misc) begin
        misc_en_ff <= reg_wr_data[psac_pkg::MISC_PSTATE_EN_BIT];
    end
end

assign boost_suspend = ctl_ff[psac_pkg::CTL_BOOST_SUSPEND_BIT];

// ----------------------------------------------------------------
// transition engine
// ----------------------------------------------------------------
psac_step_engine #(
    .POINT_MASK(POINT_MASK),
    .POINT_RESET(POINT_RESET)
) i_psac_step_engine (
    .clk(clk),
    .rst(rst),
    .feature_en(misc_en_ff),
    .req_valid(wr_ctl),
    .req_point(reg_wr_data[15:0]),
    .cur_point(cur_point),
    .busy(busy)
);

assign op_point = cur_point;
assign transition_busy = busy;

// ----------------------------------------------------------------
// register read
// ----------------------------------------------------------------
always_comb begin
    nxt_rd_data = 64'h0;
    case (sel)
        psac_pkg::SEL_REF: nxt_rd_data = ref_ff;
        psac_pkg::SEL_ACT: nxt_rd_data = act_ff;
        psac_pkg::SEL_STATUS: nxt_rd_data = {48'h0, cur_point};
        psac_pkg::SEL_CTL: nxt_rd_data = ctl_ff;
        psac_pkg::SEL_MISC: begin
            nxt_rd_data[psac_pkg::MISC_PSTATE_EN_BIT] = misc_en_ff;
        end
        default: nxt_rd_data = 64'h0;
    endcase
end

always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
        rd_data_ff <= 64'h0;
        rd_valid_ff <= 1'b0;
    end else begin
        rd_valid_ff <= reg_rd_en;
        if (reg_rd_en) begin
            rd_data_ff <= nxt_rd_data;
        end
    end
end

always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
        fault_ff <= 1'b0;
    end else begin
        fault_ff <= ((reg_rd_en || reg_wr_en) && (sel == psac_pkg::SEL_NONE))
            || (reg_wr_en && (sel == psac_pkg::SEL_STATUS));
    end
end

assign reg_rd_data = rd_data_ff;
assign reg_rd_valid = rd_valid_ff;
assign reg_fault = fault_ff;

// ----------------------------------------------------------------
// identification query
// ----------------------------------------------------------------
always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
        ecx_ff <= 32'h0;
        id_valid_ff <= 1'b0;
    end else begin
        id_valid_ff <= id_req;
        if (id_req) begin
            ecx_ff <= 32'h0;
            if (id_leaf == psac_pkg::ID_LEAF_FEATURES) begin
                ecx_ff[psac_pkg::ID_FEAT_PSTATE_BIT] <= 1'b1;
            end else if (id_leaf == psac_pkg::ID_LEAF_POWER) begin
                ecx_ff[psac_pkg::ID_POWER_COUNTERS_BIT] <= 1'b1;
            end
        end
    end
end

assign id_ecx = ecx_ff;
assign id_valid = id_valid_ff;

// ----------------------------------------------------------------
// checks
// ----------------------------------------------------------------
default clocking cb @(posedge clk);
endclocking
default disable iff (rst);

chk_ref_counts: assert property (
    ref_inc && !wrap && !wr_ref |=> ref_ff == $past(ref_ff) + 64'h1)
    else $error("reference counter failed to advance");

chk_act_counts: assert property (
    act_inc && !wrap && !wr_act |=> act_ff == $past(act_ff) + 64'h1)
    else $error("actual counter failed to advance");

chk_idle_hold: assert property (
    !c0_active && !wr_ref && !wr_act |=> $stable(ref_ff) && $stable(act_ff))
    else $error("counters moved outside c0");

chk_wrap_both: assert property (
    wrap && !wr_ref && !wr_act |=> ref_ff == 64'h0 && act_ff == 64'h0)
    else $error("wrap did not clear both counters");

chk_write_alone: assert property (
    wr_ref && !wrap && !act_inc |=> ref_ff == $past(reg_wr_data) && $stable(act_ff))
    else $error("counter write disturbed the other counter");

chk_ctl_readback: assert property (
    wr_ctl ##1 (reg_rd_en && sel == psac_pkg::SEL_CTL && !wr_ctl)
    |=> reg_rd_data == $past(reg_wr_data, 2))
    else $error("target register did not read back last request");

chk_disabled_idle: assert property (
    !busy && !misc_en_ff |=> !busy)
    else $error("transition started while disabled");

chk_point_steps: assert property (
    !$stable(cur_point) |-> $past(busy) && !busy)
    else $error("current point changed outside transition end");

chk_step_ends: assert property (
    $rose(busy) |-> busy [*8] ##1 busy [*2] ##1 !busy)
    else $error("transition length wrong");

chk_feature_id: assert property (
    id_req && id_leaf == psac_pkg::ID_LEAF_FEATURES |=> id_valid && id_ecx[7])
    else $error("feature bit missing");

chk_counter_id: assert property (
    id_req && id_leaf == psac_pkg::ID_LEAF_POWER |=> id_valid && id_ecx[0])
    else $error("counter presence bit missing");

chk_target_start: assert property (
    wr_ctl && !busy && misc_en_ff |-> ##2 busy)
    else $error("written target did not start a transition");

chk_status_live: assert property (
    reg_rd_en && sel == psac_pkg::SEL_STATUS |=> reg_rd_data == {48'h0, $past(cur_point)})
    else $error("status read did not show current point");

chk_status_fault: assert property (
    reg_wr_en && sel == psac_pkg::SEL_STATUS |=> reg_fault)
    else $error("status write not refused");

chk_boost_set: assert property (
    wr_ctl && reg_wr_data[psac_pkg::CTL_BOOST_SUSPEND_BIT] |=> boost_suspend)
    else $error("boost suspend bit not taken");

chk_misc_readback: assert property (
    reg_rd_en && sel == psac_pkg::SEL_MISC
    |=> reg_rd_data[psac_pkg::MISC_PSTATE_EN_BIT] == $past(misc_en_ff))
    else $error("enable bit did not read back");

cov_wrap: cover property (wrap);
cov_queued_target: cover property (busy && wr_ctl ##[1:20] $rose(busy));
cov_both_count: cover property (ref_inc && act_inc);
cov_boost_off: cover property ($rose(boost_suspend));

endmodule

// ### hdl/psac_pkg.sv
package psac_pkg;

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
localparam int CLK_PERIOD_NS = 10;
localparam int STEP_TIME_NS = 100;
localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
localparam logic [7:0] STEP_CNT_LAST = 8'(STEP_CYCLES - 1);

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
localparam logic [31:0] ADDR_FIXED_REF = 32'h0000_00e7;
localparam logic [31:0] ADDR_ACTUAL_PERF = 32'h0000_00e8;
localparam logic [31:0] ADDR_PERF_STATUS = 32'h0000_0198;
localparam logic [31:0] ADDR_PERF_CTL = 32'h0000_0199;
localparam logic [31:0] ADDR_MISC_ENABLE = 32'h0000_01a0;

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
localparam int MISC_PSTATE_EN_BIT = 16;
localparam int CTL_BOOST_SUSPEND_BIT = 32;
localparam int POINT_W = 16;
localparam logic [63:0] CTL_RESET = 64'h0;
localparam logic [63:0] COUNTER_RESET = 64'h0;
localparam logic [15:0] OP_POINT_RESET = 16'h0000;
localparam logic [15:0] OP_POINT_MASK = 16'hffff;

// ----------------------------------------------------------------
// identification query
// ----------------------------------------------------------------
localparam logic [31:0] ID_LEAF_FEATURES = 32'h0000_0001;
localparam logic [31:0] ID_LEAF_POWER = 32'h0000_0006;
localparam int ID_FEAT_PSTATE_BIT = 7;
localparam int ID_POWER_COUNTERS_BIT = 0;

// ----------------------------------------------------------------
// types
// ----------------------------------------------------------------
typedef enum {SEL_NONE, SEL_REF, SEL_ACT, SEL_STATUS, SEL_CTL, SEL_MISC} psac_sel_type;
typedef enum {ST_IDLE, ST_MOVE} psac_step_state_type;

endpackage

// ### hdl/psac_step_engine.sv
`timescale 1ns/1ns
module psac_step_engine #(
    parameter logic [15:0] POINT_MASK = psac_pkg::OP_POINT_MASK,
    parameter logic [15:0] POINT_RESET = psac_pkg::OP_POINT_RESET
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic feature_en,
    input wire logic req_valid,
    input wire logic [15:0] req_point,
    output logic [15:0] cur_point,
    output logic busy
);

psac_pkg::psac_step_state_type state_ff;
logic [15:0] pend_ff;
logic pend_valid_ff;
logic [15:0] target_ff;
logic [15:0] cur_ff;
logic [7:0] cnt_ff;
logic start;

assign start = (state_ff == psac_pkg::ST_IDLE) && pend_valid_ff && feature_en;
assign cur_point = cur_ff;
assign busy = (state_ff == psac_pkg::ST_MOVE);

// ----------------------------------------------------------------
// pending request, newest wins
// ----------------------------------------------------------------
always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
        pend_ff <= POINT_RESET;
        pend_valid_ff <= 1'b0;
    end else if (req_valid) begin
        pend_ff <= req_point & POINT_MASK;
        pend_valid_ff <= 1'b1;
    end else if (start) begin
        pend_valid_ff <= 1'b0;
    end
end

// ----------------------------------------------------------------
// transition sequencer
// ----------------------------------------------------------------
always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
        state_ff <= psac_pkg::ST_IDLE;
        cnt_ff <= 8'h00;
        target_ff <= POINT_RESET;
        cur_ff <= POINT_RESET;
    end else begin
        case (state_ff)
            psac_pkg::ST_IDLE: begin
                if (start) begin
                    state_ff <= psac_pkg::ST_MOVE;
                    target_ff <= pend_ff;
                    cnt_ff <= 8'h00;
                end
            end
            psac_pkg::ST_MOVE: begin
                if (cnt_ff == psac_pkg::STEP_CNT_LAST) begin
                    state_ff <= psac_pkg::ST_IDLE;
                    cur_ff <= target_ff;
                end else begin
                    cnt_ff <= cnt_ff + 8'h01;
                end
            end
            default: state_ff <= psac_pkg::ST_IDLE;
        endcase
    end
end

endmodule

// ### tb/test_perf_state_activity_counters.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_perf_state_activity_counters;
// ----------------------------------------------------------------
// signals and design
// ----------------------------------------------------------------
localparam logic [31:0] A_REF = psac_pkg::ADDR_FIXED_REF;
localparam logic [31:0] A_ACT = psac_pkg::ADDR_ACTUAL_PERF;
localparam logic [31:0] A_ST = psac_pkg::ADDR_PERF_STATUS;
localparam logic [31:0] A_CTL = psac_pkg::ADDR_PERF_CTL;
localparam logic [31:0] A_MISC = psac_pkg::ADDR_MISC_ENABLE;
logic clk = 0, rst = 1, rde = 0, wre = 0, idq = 0, c0 = 0, rt = 0, pt = 0;
logic [31:0] adr = 0, leaf = 0;
logic [63:0] wd = 0, er, ea, e64;
logic [31:0] e32;
logic [15:0] e16, last_pt = 0;
logic [2:0] r3;
wire logic [63:0] rdd;
wire logic [31:0] ecx;
wire logic [15:0] opp;
wire logic rdv, flt, idv, busy, bsus;
int mismatches = 0, checks = 0, seed = 32'hd1f0, nflt = 0;
logic [63:0] q_rd[$];
logic [31:0] q_id[$];
logic [15:0] q_pt[$];
psac_perf_counters i_psac_perf_counters (.clk(clk), .rst(rst), .reg_rd_en(rde),
    .reg_wr_en(wre), .reg_addr(adr), .reg_wr_data(wd), .reg_rd_data(rdd),
    .reg_rd_valid(rdv), .reg_fault(flt), .id_req(idq), .id_leaf(leaf), .id_ecx(ecx),
    .id_valid(idv), .c0_active(c0), .ref_tick(rt), .perf_tick(pt), .op_point(opp),
    .transition_busy(busy), .boost_suspend(bsus));
initial begin
    forever #5 clk = ~clk;
end
// ----------------------------------------------------------------
// drivers and result watcher
// ----------------------------------------------------------------
task rd(input logic [31:0] a, input logic [63:0] e);
    @(negedge clk);
    rde = 1; wre = 0; idq = 0; adr = a;
    q_rd.push_back(e);
endtask
task wr(input logic [31:0] a, input logic [63:0] d);
    @(negedge clk);
    wre = 1; rde = 0; idq = 0; adr = a; wd = d;
endtask
task idr(input logic [31:0] l, input logic [31:0] e);
    @(negedge clk);
    idq = 1; rde = 0; wre = 0; leaf = l;
    q_id.push_back(e);
endtask
task tick(input logic c, input logic r, input logic p);
    @(negedge clk);
    rde = 0; wre = 0; idq = 0; c0 = c; rt = r; pt = p;
endtask
task wait_step(input int e);
    int n, b;
    n = 0;
    b = 0;
    tick(0, 0, 0);
    while (busy !== 1'b1 && n < 50) begin
        @(negedge clk);
        n++;
    end
    while (busy === 1'b1 && b < 50) begin
        @(negedge clk);
        b++;
    end
    if (e > 0) `CHK("busy_cycles", e, b)
endtask
task finish_test;
    if (mismatches == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask
always @(negedge clk) begin
    if (!rst) begin
        if (rdv === 1'b1) begin
            e64 = q_rd.size() > 0 ? q_rd.pop_front() : 'x;
            `CHK("rd_data", e64, rdd)
        end
        if (idv === 1'b1) begin
            e32 = q_id.size() > 0 ? q_id.pop_front() : 'x;
            `CHK("id_ecx", e32, ecx)
        end
        if (opp !== last_pt) begin
            e16 = q_pt.size() > 0 ? q_pt.pop_front() : 'x;
            `CHK("op_point", e16, opp)
            last_pt = opp;
        end
        if (flt === 1'b1) begin
            `CHK("fault", 1'b1, nflt > 0)
            nflt--;
        end
    end
end
initial begin
    #100000;
    mismatches++;
    finish_test;
end
// ----------------------------------------------------------------
// main sequence
// ----------------------------------------------------------------
initial begin
    repeat (20) @(negedge clk);
    rst = 0;
    rd(A_CTL, psac_pkg::CTL_RESET);
    rd(A_REF, 0);
    rd(A_ACT, 0);
    rd(A_MISC, 0);
    idr(32'h1, 32'h80);
    idr(32'h6, 32'h1);
    idr(32'h2, 32'h0);
    wr(A_CTL, 64'h42);
    repeat (15) tick(0, 0, 0);
    `CHK("busy_off", 1'b0, busy)
    rd(A_CTL, 64'h42);
    rd(A_ST, 0);
    q_pt.push_back(16'h42);
    wr(A_MISC, '1);
    wait_step(psac_pkg::STEP_CYCLES);
    rd(A_MISC, 64'h1_0000);
    rd(A_ST, 64'h42);
    q_pt.push_back(16'h11);
    q_pt.push_back(16'hc3);
    wr(A_CTL, 64'h11);
    repeat (3) tick(0, 0, 0);
    wr(A_CTL, 64'h55);
    wr(A_CTL, 64'h1_0000_00c3);
    rd(A_CTL, 64'h1_0000_00c3);
    wait_step(0);
    wait_step(psac_pkg::STEP_CYCLES);
    `CHK("boost", 1'b1, bsus)
    rd(A_ST, 64'hc3);
    nflt += 2;
    wr(A_ST, 64'h7);
    rd(32'h1234, 0);
    rd(A_ST, 64'hc3);
    wr(A_REF, 0);
    wr(A_ACT, 0);
    er = 0;
    ea = 0;
    repeat (60) begin
        r3 = 3'($random(seed));
        tick(r3[0], r3[1], r3[2]);
        if (r3[0]) begin
            er += 64'(r3[1]);
            ea += 64'(r3[2]);
        end
    end
    tick(0, 0, 0);
    rd(A_REF, er);
    rd(A_ACT, ea);
    for (int i = 0; i < 2; i++) begin
        wr(A_REF, i ? 64'h9 : '1);
        wr(A_ACT, i ? '1 : 64'h5);
        tick(1, i == 0, i == 1);
        tick(0, 0, 0);
        rd(A_REF, 0);
        rd(A_ACT, 0);
    end
    wr(A_REF, 64'h1234_5678_9abc_def0);
    rd(A_ACT, 0);
    rd(A_REF, 64'h1234_5678_9abc_def0);
    tick(0, 0, 0);
    q_pt.push_back(16'h0);
    @(negedge clk);
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    rd(A_REF, 0);
    rd(A_CTL, psac_pkg::CTL_RESET);
    rd(A_MISC, 0);
    repeat (4) tick(0, 0, 0);
    `CHK("boost_rst", 1'b0, bsus)
    `CHK("pending", 0, q_rd.size() + q_id.size() + q_pt.size() + nflt)
    finish_test;
end
endmodule
